// >>> hdl/cpt_config_regs.sv
// charger protection, timing and thermistor configuration register bank
module cpt_config_regs
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] reg_rdata_o,
    input wire logic wdog_expire_i,
    input wire logic opt_started_i,
    input wire logic [2:0] therm_zone_i,
    output logic [1:0] discharge_overcurrent_level_o,
    output logic battery_undervoltage_select_o,
    output logic boost_min_battery_select_o,
    output logic external_limit_pin_enable_o,
    output logic optimizer_enable_o,
    output logic optimizer_start_o,
    output logic [2:0] power_good_threshold_o,
    output logic system_reset_time_select_o,
    output logic low_power_exit_time_select_o,
    output logic system_discharge_enable_o,
    output logic [1:0] precharge_threshold_o,
    output logic [1:0] charge_rate_select_o,
    output logic [1:0] boost_hot_threshold_o,
    output logic boost_cold_threshold_o,
    output logic coldest_comparator_threshold_o,
    output logic hottest_comparator_threshold_o,
    output logic [2:0] thermistor_status_o,
    output logic timer_reset_o
);
    // =========================================================
    // register storage and write decode
    // =========================================================
    localparam logic [2:0] THERMISTOR_STATUS_NORMAL_CODE = 3'h0;
    logic [7:0] prot_q;
    logic [7:0] prot_d;
    logic [7:0] pgt_q;
    logic [7:0] pgt_d;
    logic [7:0] thb_q;
    logic [7:0] thb_d;
    logic soft_rst_q;
    logic wr_prot;
    logic wr_pgt;
    logic wr_thb;
    logic wr_rst;
    logic force_set;
    logic force_flag;
    logic [7:0] prot_view;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    assign wr_prot = reg_wr_i & hit(reg_addr_i, cpt_pkg::PROT_OPT_ADDR);
    assign wr_pgt = reg_wr_i & hit(reg_addr_i, cpt_pkg::PGOOD_TIME_ADDR);
    assign wr_thb = reg_wr_i & hit(reg_addr_i, cpt_pkg::THERM_BOOST_ADDR);
    assign wr_rst = reg_wr_i & hit(reg_addr_i, cpt_pkg::RST_CTRL_ADDR)
        & reg_wdata_i[cpt_pkg::REG_RST_BIT];
    // writing zero to the force bit is a no-op
    assign force_set = wr_prot & reg_wdata_i[cpt_pkg::FORCE_OPT_BIT];

    // soft reset acts one cycle after the write, then the bit drops
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            soft_rst_q <= 1'b0;
        else
            soft_rst_q <= wr_rst;
    end
    assign timer_reset_o = soft_rst_q;

    // protection register: force bit lives in its own module
    always_comb
    begin
        prot_d = prot_q;
        if (wr_prot)
            prot_d = reg_wdata_i & cpt_pkg::PROT_OPT_WMASK;
        if (soft_rst_q)
            prot_d = cpt_pkg::PROT_OPT_RST;
        if (wdog_expire_i)
            prot_d[cpt_pkg::EXT_LIM_BIT] = 1'b1;
        prot_d[cpt_pkg::FORCE_OPT_BIT] = 1'b0;
    end

    // timing and precharge fields keep their value on soft resets
    always_comb
    begin
        pgt_d = wr_pgt ? reg_wdata_i : pgt_q;
        if (soft_rst_q)
            pgt_d = {cpt_pkg::PGOOD_TIME_RST[7:5], pgt_q[4:3],
                cpt_pkg::PGOOD_TIME_RST[2], pgt_q[1:0]};
        if (wdog_expire_i)
            pgt_d[cpt_pkg::SYS_DSCHG_BIT] = 1'b0;
    end

    always_comb
    begin
        thb_d = wr_thb ? reg_wdata_i : thb_q;
        if (soft_rst_q)
            thb_d = cpt_pkg::THERM_BOOST_RST;
        if (wdog_expire_i)
            thb_d[cpt_pkg::TS_IGN_BIT] = 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prot_q <= cpt_pkg::PROT_OPT_RST;
            pgt_q <= cpt_pkg::PGOOD_TIME_RST;
            thb_q <= cpt_pkg::THERM_BOOST_RST;
        end
        else
        begin
            prot_q <= prot_d;
            pgt_q <= pgt_d;
            thb_q <= thb_d;
        end
    end

    cpt_force_start u_force
    (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .set_i(force_set),
        .enable_i(prot_q[cpt_pkg::OPT_EN_BIT]),
        .wdog_clr_i(wdog_expire_i),
        .started_i(opt_started_i),
        .flag_o(force_flag),
        .start_o(optimizer_start_o)
    );

    // =========================================================
    // read path and field outputs
    // =========================================================
    assign prot_view = {prot_q[7:2], force_flag, prot_q[0]};
    assign reg_rdata_o =
        hit(reg_addr_i, cpt_pkg::PROT_OPT_ADDR) ? prot_view :
        hit(reg_addr_i, cpt_pkg::PGOOD_TIME_ADDR) ? pgt_q :
        hit(reg_addr_i, cpt_pkg::THERM_BOOST_ADDR) ? thb_q :
        8'h00;

    assign discharge_overcurrent_level_o = prot_q[cpt_pkg::OCP_LSB +: 2];
    assign battery_undervoltage_select_o = prot_q[cpt_pkg::UVLO_BIT];
    assign boost_min_battery_select_o = prot_q[cpt_pkg::BOOST_MIN_BIT];
    assign external_limit_pin_enable_o = prot_q[cpt_pkg::EXT_LIM_BIT];
    assign optimizer_enable_o = prot_q[cpt_pkg::OPT_EN_BIT];
    assign power_good_threshold_o = pgt_q[cpt_pkg::PG_LSB +: 3];
    assign system_reset_time_select_o = pgt_q[cpt_pkg::SYS_RST_TIME_BIT];
    assign low_power_exit_time_select_o = pgt_q[cpt_pkg::LP_EXIT_BIT];
    assign system_discharge_enable_o = pgt_q[cpt_pkg::SYS_DSCHG_BIT];
    assign precharge_threshold_o = pgt_q[cpt_pkg::PRECHG_LSB +: 2];
    assign charge_rate_select_o = thb_q[cpt_pkg::RATE_LSB +: 2];
    assign boost_hot_threshold_o = thb_q[cpt_pkg::BHOT_LSB +: 2];
    assign boost_cold_threshold_o = thb_q[cpt_pkg::BCOLD_BIT];
    assign coldest_comparator_threshold_o = thb_q[cpt_pkg::COLDEST_BIT];
    assign hottest_comparator_threshold_o = thb_q[cpt_pkg::HOTTEST_BIT];
    // ignore overrides the sensed zone for charging and boost decisions
    assign thermistor_status_o = thb_q[cpt_pkg::TS_IGN_BIT] ?
        THERMISTOR_STATUS_NORMAL_CODE : therm_zone_i;

    // =========================================================
    // assertions
    // =========================================================
    property p_reserved_zero;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        prot_q[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_soft_default;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_rst && !wdog_expire_i ##1 !wdog_expire_i |=>
        prot_q == cpt_pkg::PROT_OPT_RST && thb_q == cpt_pkg::THERM_BOOST_RST;
    endproperty
    a_soft_default: assert property (p_soft_default)
        else $error("defaults not restored");

    property p_timing_keep;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        soft_rst_q && !wr_pgt |=> $stable(pgt_q[4:0] & 5'h1B);
    endproperty
    a_timing_keep: assert property (p_timing_keep)
        else $error("timing field lost");

    property p_wdog_clear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wdog_expire_i |=> !system_discharge_enable_o
            && external_limit_pin_enable_o
            && !thb_q[cpt_pkg::TS_IGN_BIT] && force_flag == $past(force_set);
    endproperty
    a_wdog_clear: assert property (p_wdog_clear)
        else $error("watchdog defaults wrong");

    property p_force_gate;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !optimizer_enable_o |-> !optimizer_start_o;
    endproperty
    a_force_gate: assert property (p_force_gate)
        else $error("start while disabled");

    property p_force_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        force_set |=> force_flag;
    endproperty
    a_force_set: assert property (p_force_set)
        else $error("force write lost");

    property p_force_ack;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        optimizer_start_o && opt_started_i && !force_set |=> !force_flag;
    endproperty
    a_force_ack: assert property (p_force_ack)
        else $error("force bit stuck");

    property p_ignore;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        thb_q[cpt_pkg::TS_IGN_BIT] |-> thermistor_status_o == THERMISTOR_STATUS_NORMAL_CODE;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("ignore not honoured");

    property p_rst_pulse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        timer_reset_o && !wr_rst |=> !timer_reset_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset bit not cleared");

    property p_write_prot;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_prot && !soft_rst_q && !wdog_expire_i |=>
        prot_q == ($past(reg_wdata_i) & cpt_pkg::PROT_OPT_WMASK & 8'hFD);
    endproperty
    a_write_prot: assert property (p_write_prot)
        else $error("protection register write lost");

    property p_write_pgt;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_pgt && !soft_rst_q && !wdog_expire_i |=>
        pgt_q == $past(reg_wdata_i);
    endproperty
    a_write_pgt: assert property (p_write_pgt)
        else $error("timing register write lost");

    property p_write_thb;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_thb && !soft_rst_q && !wdog_expire_i |=>
        thb_q == $past(reg_wdata_i);
    endproperty
    a_write_thb: assert property (p_write_thb)
        else $error("thermistor register write lost");

    property p_unmapped_read;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !hit(reg_addr_i, cpt_pkg::PROT_OPT_ADDR)
            && !hit(reg_addr_i, cpt_pkg::PGOOD_TIME_ADDR)
            && !hit(reg_addr_i, cpt_pkg::THERM_BOOST_ADDR)
            |-> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_force_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !force_set && !wdog_expire_i && !(optimizer_start_o && opt_started_i)
            |=> $stable(force_flag);
    endproperty
    a_force_hold: assert property (p_force_hold)
        else $error("force bit changed unasked");

    property p_soft_pgood;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        soft_rst_q |=> power_good_threshold_o == cpt_pkg::PGOOD_TIME_RST[7:5]
            && !system_discharge_enable_o;
    endproperty
    a_soft_pgood: assert property (p_soft_pgood)
        else $error("soft reset left discharge on");

    c_soft: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        soft_rst_q);
    c_start: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        optimizer_start_o ##1 !force_flag);
    c_wdog: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wdog_expire_i && system_discharge_enable_o);
    c_gated: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        force_flag && !optimizer_enable_o);
    c_ignore: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        thb_q[cpt_pkg::TS_IGN_BIT] && therm_zone_i != 3'h0);
endmodule : cpt_config_regs

// >>> hdl/cpt_pkg.sv
// package: register map, field layout, reset values and thresholds
package cpt_pkg;
    // register offsets
    localparam logic [7:0] PROT_OPT_ADDR = 8'h19;
    localparam logic [7:0] PGOOD_TIME_ADDR = 8'h1A;
    localparam logic [7:0] THERM_BOOST_ADDR = 8'h1C;
    localparam logic [7:0] RST_CTRL_ADDR = 8'h17;
    // register reset values
    localparam logic [7:0] PROT_OPT_RST = 8'h85;
    localparam logic [7:0] PGOOD_TIME_RST = 8'h00;
    localparam logic [7:0] THERM_BOOST_RST = 8'h0F;
    // writable bit masks; reserved bits stay zero
    localparam logic [7:0] PROT_OPT_WMASK = 8'hF7;
    // field positions, protection_and_optimizer_control
    localparam int OCP_LSB = 6;
    localparam int UVLO_BIT = 5;
    localparam int BOOST_MIN_BIT = 4;
    localparam int EXT_LIM_BIT = 2;
    localparam int FORCE_OPT_BIT = 1;
    localparam int OPT_EN_BIT = 0;
    // field positions, power_good_and_timing_control
    localparam int PG_LSB = 5;
    localparam int SYS_RST_TIME_BIT = 4;
    localparam int LP_EXIT_BIT = 3;
    localparam int SYS_DSCHG_BIT = 2;
    localparam int PRECHG_LSB = 0;
    // field positions, thermistor_boost_threshold_control
    localparam int TS_IGN_BIT = 7;
    localparam int RATE_LSB = 5;
    localparam int BHOT_LSB = 3;
    localparam int BCOLD_BIT = 2;
    localparam int COLDEST_BIT = 1;
    localparam int HOTTEST_BIT = 0;
    // register reset control bit
    localparam int REG_RST_BIT = 7;
    // codes of note
    localparam logic [1:0] OCP_RESERVED = 2'h3;
    localparam logic [2:0] PG_RESERVED = 3'h7;
    localparam logic [1:0] BHOT_DISABLE = 2'h3;
    // timing figures
    localparam int SYS_RST_SHORT_S = 11;
    localparam int SYS_RST_LONG_S = 21;
    localparam int LP_EXIT_SHORT_MS = 700;
    localparam int LP_EXIT_LONG_MS = 10500;
    localparam int CLK_MHZ = 100;
endpackage : cpt_pkg

// >>> hdl/cpt_force_start.sv
// self-clearing optimizer force-start bit
module cpt_force_start
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic set_i,
    input wire logic enable_i,
    input wire logic wdog_clr_i,
    input wire logic started_i,
    output logic flag_o,
    output logic start_o
);
    logic flag_q;
    logic flag_d;
    // the start request reaches the optimizer only while it is enabled
    assign start_o = flag_q & enable_i;
    // set beats a same-cycle start or watchdog clear so a write is never lost
    assign flag_d = set_i ? 1'b1 :
        ((wdog_clr_i | (started_i & start_o)) ? 1'b0 : flag_q);
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
    assign flag_o = flag_q;
endmodule : cpt_force_start

// >>> verif/testbench.sv
// self-checking bench for the configuration register bank
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // signals and model state
    logic ref_clk_i;
    logic resetn_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic [7:0] reg_rdata_o;
    logic wdog_expire_i;
    logic opt_started_i;
    logic [2:0] therm_zone_i;
    logic [1:0] ocp_o, prechg_o, rate_o, bhot_o;
    logic uv_o, bmin_o, ext_o, opten_o, start_o, srt_o, lpx_o, dsch_o;
    logic bcold_o, coldest_o, hottest_o, timer_reset_o;
    logic [2:0] pg_o, tstat_o;
    logic [7:0] m19, m1a, m1c;
    logic mf, exp_tr;
    logic [31:0] rnd;
    logic [7:0] tab [5];
    int n_errors, total_checks;

    cpt_config_regs DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
        .wdog_expire_i(wdog_expire_i), .opt_started_i(opt_started_i),
        .therm_zone_i(therm_zone_i), .discharge_overcurrent_level_o(ocp_o),
        .battery_undervoltage_select_o(uv_o),
        .boost_min_battery_select_o(bmin_o),
        .external_limit_pin_enable_o(ext_o), .optimizer_enable_o(opten_o),
        .optimizer_start_o(start_o), .power_good_threshold_o(pg_o),
        .system_reset_time_select_o(srt_o),
        .low_power_exit_time_select_o(lpx_o),
        .system_discharge_enable_o(dsch_o), .precharge_threshold_o(prechg_o),
        .charge_rate_select_o(rate_o), .boost_hot_threshold_o(bhot_o),
        .boost_cold_threshold_o(bcold_o),
        .coldest_comparator_threshold_o(coldest_o),
        .hottest_comparator_threshold_o(hottest_o),
        .thermistor_status_o(tstat_o), .timer_reset_o(timer_reset_o));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        // bit 1 of 0x19 is the separate force flag
        case (a)
            8'h19: exp_rd = {m19[7:2], mf, m19[0]};
            8'h1A: exp_rd = m1a;
            8'h1C: exp_rd = m1c;
            default: exp_rd = 8'h00;
        endcase
    endfunction : exp_rd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    task automatic check_all();
        chk({ocp_o, uv_o, bmin_o, ext_o, opten_o}, {m19[7:4], m19[2], m19[0]});
        chk({pg_o, srt_o, lpx_o, dsch_o, prechg_o}, m1a);
        chk({rate_o, bhot_o, bcold_o, coldest_o, hottest_o}, m1c[6:0]);
        chk(start_o, mf & m19[0]);
        chk(tstat_o, m1c[7] ? 3'h0 : therm_zone_i);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge ref_clk_i);
            reg_addr_i <= tab[i];
            #1 chk(reg_rdata_o, exp_rd(tab[i]));
        end
    endtask : check_all

    // one cycle of stimulus, then the model follows and all is compared
    task automatic drive(input logic [7:0] a, input logic [7:0] d,
        input logic w, input logic wd, input logic os);
        rnd = lfsr(rnd);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        wdog_expire_i <= wd;
        opt_started_i <= os;
        therm_zone_i <= rnd[2:0];
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        wdog_expire_i <= 1'b0;
        opt_started_i <= 1'b0;
        if (os && m19[0])
            mf = 1'b0;
        if (w && a == 8'h19)
        begin
            m19 = d & 8'hF5;
            mf = mf | d[1];
        end
        if (w && a == 8'h1A)
            m1a = d;
        if (w && a == 8'h1C)
            m1c = d;
        exp_tr = w && a == 8'h17 && d[7];
        if (wd)
        begin
            // watchdog wins over a write, except a same-cycle force set
            m19[2] = 1'b1;
            mf = w && a == 8'h19 && d[1];
            m1a[2] = 1'b0;
            m1c[7] = 1'b0;
        end
        #1 chk(timer_reset_o, exp_tr);
        if (exp_tr)
        begin
            @(posedge ref_clk_i);
            m19 = 8'h85;
            m1a = m1a & 8'h1B;
            m1c = 8'h0F;
            exp_tr = 1'b0;
            #1 chk(timer_reset_o, 1'b0);
        end
        check_all();
    endtask : drive

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // clock, watchdog and main sequence
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        tab = '{8'h19, 8'h1A, 8'h1C, 8'h17, 8'h1B};
        rnd = 32'hb2b5b09b;
        {resetn_i, reg_wr_i, wdog_expire_i, opt_started_i} = 4'h0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        therm_zone_i = 3'h0;
        {m19, m1a, m1c, mf, exp_tr} = {8'h85, 8'h00, 8'h0F, 2'b00};
        n_errors = 0;
        total_checks = 0;
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        check_all();
        // force flag: set-only, gated by enable, cleared on start
        drive(8'h19, 8'hFF, 1'b1, 1'b0, 1'b0);
        drive(8'h19, 8'h00, 1'b1, 1'b0, 1'b0);
        drive(8'h19, 8'h03, 1'b1, 1'b0, 1'b0);
        drive(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        drive(8'h19, 8'h03, 1'b1, 1'b0, 1'b1);
        // every code of the multi-bit fields except the precharge threshold, held at 01
        for (int i = 0; i < 8; i++)
        begin
            drive(8'h19, {i[1:0], 6'h01}, 1'b1, 1'b0, 1'b0);
            drive(8'h1A, {i[2:0], 5'h15}, 1'b1, 1'b0, 1'b0);
            drive(8'h1C, {i[0], i[1:0], i[2:1], 3'h2}, 1'b1, 1'b0, 1'b0);
        end
        // watchdog over a fully set bank, then soft resets, one with a same-cycle watchdog
        drive(8'h1A, 8'hFF, 1'b1, 1'b0, 1'b0);
        drive(8'h1C, 8'hFF, 1'b1, 1'b0, 1'b0);
        drive(8'h19, 8'hFF, 1'b1, 1'b0, 1'b0);
        drive(8'h1B, 8'hFF, 1'b1, 1'b1, 1'b0);
        drive(8'h1C, 8'h80, 1'b1, 1'b0, 1'b0);
        drive(8'h19, 8'hFB, 1'b1, 1'b0, 1'b0);
        drive(8'h17, 8'h80, 1'b1, 1'b0, 1'b0);
        drive(8'h1A, 8'hE4, 1'b1, 1'b0, 1'b0);
        drive(8'h17, 8'h80, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 60; i++)
        begin
            rnd = lfsr(rnd);
            drive(tab[rnd[2:0] % 5], rnd[15:8], 1'b1, rnd[18:16] == 3'h0,
                rnd[21:19] == 3'h0);
        end
        report_and_stop();
    end
endmodule : testbench
